// >>> rtl/bss_front.sv
// control and address capture front end of a pipelined burst sram
module bss_front
    import bss_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    input  wire logic                  clk_en,
    input  wire bss_pkg::bss_ctl_t     ctl,
    input  wire logic                  out_enable_n,
    input  wire logic                  burst_order_strap,
    input  wire logic [31:0]           array_rdata,
    input  wire logic [31:0]           data_in,
    output logic                       burst_interleaved,
    output bss_pkg::bss_access_t       access,
    output logic [31:0]                wdata,
    output logic [31:0]                data_out,
    output logic [LANES-1:0]           data_oe
);
    import bss_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0]  base;
        logic [BURST_W-1:0] count;
        logic               selected;
        bss_cycle_t         cycle;
        logic               first_read;
        logic               order_valid;
        logic [1:0]         order_wait;
        logic               interleaved;
        bss_access_t        access;
        logic [31:0]        wdata;
        logic [31:0]        dout;
        logic [LANES-1:0]   oe;
        logic               read_pend;
    } bss_state_t;

    bss_state_t state;
    bss_state_t next_state;
    logic [1:0] pins_sync;
    logic       oe_n_s;
    logic       strap_s;

    // ************************************************************
    // asynchronous pins
    // ************************************************************
    bss_sync #(.WIDTH(2)) u_sync (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .clk_en      (clk_en),
        .reset_value (2'h3),
        .async_in    ({out_enable_n, burst_order_strap}),
        .sync_out    (pins_sync)
    );
    assign oe_n_s  = pins_sync[1];
    assign strap_s = pins_sync[0];

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [BURST_W-1:0] burst_addr(input logic [BURST_W-1:0] start,
                                                     input logic [BURST_W-1:0] cnt,
                                                     input logic               ilv);
        // interleaved xors the step, linear adds it with wrap
        burst_addr = ilv ? (start ^ cnt) : BURST_W'(start + cnt);
    endfunction

    function automatic logic [LANES-1:0] lanes_written(input bss_ctl_t c);
        if (!c.all_bytes_write_n) begin
            lanes_written = ALL_LANES;
        end else if (!c.lane_write_enable_n) begin
            lanes_written = ~c.lane_write_sel_n;
        end else begin
            lanes_written = NO_LANES;
        end
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    logic             cpu_take;
    logic             ctl_take;
    logic             sel_now;
    logic [LANES-1:0] lw_now;

    always_comb begin
        next_state = state;
        sel_now    = !ctl.select_pipe_n && ctl.select_depth_hi && !ctl.select_depth_lo_n;
        // pipe select high blanks the cpu strobe entirely
        cpu_take   = !ctl.cpu_addr_strobe_n && !ctl.select_pipe_n;
        // cpu strobe with pipe select low means the controller strobe is not looked at
        // controller strobe yields only to a cpu strobe that counts
        ctl_take   = !ctl.ctl_addr_strobe_n && !cpu_take;
        lw_now     = lanes_written(ctl);
        if (clk_en) begin
            // strap caught once after reset, kept static
            // wait out the synchroniser before trusting the strap
            if (!state.order_valid) begin
                if (state.order_wait == 2'(SYNC_STAGES)) begin
                    next_state.order_valid = 1'b1;
                    next_state.interleaved = strap_s;
                end else begin
                    next_state.order_wait = state.order_wait + 2'h1;
                end
            end
            next_state.access.read_issue = 1'b0;
            next_state.access.lane_write = NO_LANES;
            next_state.first_read        = 1'b0;
            if (cpu_take || ctl_take) begin
                // chip enables only sampled on a load edge
                next_state.selected = sel_now;
                if (sel_now) begin
                    next_state.base  = ctl.addr;
                    next_state.count = BURST_ZERO;
                    // cpu-started cycles are always reads; writes follow later
                    if (ctl_take && (lw_now != NO_LANES)) begin
                        next_state.cycle = BSS_WRITE;
                    end else begin
                        next_state.cycle = BSS_READ;
                    end
                    next_state.first_read = !state.selected;
                end else begin
                    next_state.cycle = BSS_IDLE;
                end
            end else if (state.selected && !ctl.burst_step_n) begin
                next_state.count = BURST_W'(state.count + BURST_ONE);
                next_state.cycle = (lw_now != NO_LANES) ? BSS_WRITE : BSS_READ;
            end else if (state.selected && (lw_now != NO_LANES)) begin
                next_state.cycle = BSS_WRITE;
            end else begin
                // suspended edge issues nothing; dout still takes the read issued one edge earlier
                next_state.cycle = BSS_IDLE;
            end
            next_state.access.selected = next_state.selected;
            next_state.access.addr = {next_state.base[ADDR_W-1:BURST_W],
                burst_addr(next_state.base[BURST_W-1:0], next_state.count, next_state.interleaved)};
            if (next_state.selected) begin
                next_state.access.read_issue = (next_state.cycle == BSS_READ);
                next_state.access.lane_write = (next_state.cycle == BSS_WRITE) ? lw_now : NO_LANES;
            end
            next_state.wdata     = data_in;
            // array answers for the address registered one edge earlier
            // first read out of deselect never arms the drive
            next_state.read_pend = state.access.read_issue && !state.first_read;
            if (state.access.read_issue) begin
                next_state.dout = array_rdata;
            end
            // output control is a level here; first read clock masked
            next_state.oe = (!oe_n_s && state.read_pend) ? ALL_LANES : NO_LANES;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= '{base: '0, count: BURST_ZERO, selected: 1'b0, cycle: BSS_IDLE, first_read: 1'b0,
                       order_valid: 1'b0, order_wait: 2'h0, interleaved: 1'b1, access: '0, wdata: '0, dout: '0,
                       oe: NO_LANES, read_pend: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign burst_interleaved = state.interleaved;
    assign access            = state.access;
    assign wdata             = state.wdata;
    assign data_out          = state.dout;
    assign data_oe           = state.oe;

    // ************************************************************
    // checks
    // ************************************************************
    property p_load_addr;
        @(posedge mclk) disable iff (sys_rst)
        (clk_en && !ctl.cpu_addr_strobe_n && !ctl.select_pipe_n && ctl.select_depth_hi && !ctl.select_depth_lo_n)
            |=> (state.base == $past(ctl.addr) && state.count == BURST_ZERO);
    endproperty
    a_load_addr: assert property (p_load_addr) else $error("address not loaded on cpu strobe");

    property p_cpu_ignored;
        @(posedge mclk) disable iff (sys_rst)
        (clk_en && !ctl.cpu_addr_strobe_n && ctl.select_pipe_n && ctl.ctl_addr_strobe_n)
            |=> $stable(state.selected) && $stable(state.base);
    endproperty
    a_cpu_ignored: assert property (p_cpu_ignored) else $error("cpu strobe acted with pipe select high");

    property p_step;
        @(posedge mclk) disable iff (sys_rst)
        (clk_en && state.selected && ctl.cpu_addr_strobe_n && ctl.ctl_addr_strobe_n && !ctl.burst_step_n)
            |=> state.count == BURST_W'($past(state.count) + BURST_ONE);
    endproperty
    a_step: assert property (p_step) else $error("burst counter did not step");

    property p_hold;
        @(posedge mclk) disable iff (sys_rst)
        (clk_en && ctl.cpu_addr_strobe_n && ctl.ctl_addr_strobe_n)
            |=> $stable(state.selected) && $stable(state.base);
    endproperty
    a_hold: assert property (p_hold) else $error("chip enables used without load");

    property p_global;
        @(posedge mclk) disable iff (sys_rst)
        (clk_en && state.selected && !ctl.all_bytes_write_n && ctl.cpu_addr_strobe_n
            && (ctl.ctl_addr_strobe_n || sel_now)) |=> access.lane_write == ALL_LANES;
    endproperty
    a_global: assert property (p_global) else $error("all-bytes write missed a lane");

    property p_lane;
        @(posedge mclk) disable iff (sys_rst)
        (clk_en && ctl.all_bytes_write_n && ctl.lane_write_enable_n) |=> access.lane_write == NO_LANES;
    endproperty
    a_lane: assert property (p_lane) else $error("lane written without lane enable");

    property p_first_mask;
        @(posedge mclk) disable iff (sys_rst)
        (clk_en && state.first_read ##1 clk_en) |=> data_oe == NO_LANES;
    endproperty
    a_first_mask: assert property (p_first_mask) else $error("first read clock drove data");

    property p_oe_off;
        @(posedge mclk) disable iff (sys_rst)
        (clk_en && oe_n_s) |=> data_oe == NO_LANES;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("data driven with output control high");

    property p_rdata;
        @(posedge mclk) disable iff (sys_rst)
        (clk_en && access.read_issue) |=> data_out == $past(array_rdata);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data not from previous address");

    property p_priority;
        @(posedge mclk) disable iff (sys_rst)
        (clk_en && !ctl.cpu_addr_strobe_n && !ctl.ctl_addr_strobe_n && !ctl.select_pipe_n && ctl.select_depth_hi
            && !ctl.select_depth_lo_n) |=> state.cycle == BSS_READ;
    endproperty
    a_priority: assert property (p_priority) else $error("controller strobe acted beside cpu strobe");
endmodule // bss_front

// >>> rtl/bss_pkg.sv
// package: widths, lane and burst constants, cycle kinds and carrier structs for the burst sram front end
package bss_pkg;
    localparam int ADDR_W      = 20;
    localparam int LANES       = 4;
    localparam int BURST_W     = 2;
    localparam int SYNC_STAGES = 2;
    localparam logic [LANES-1:0] ALL_LANES = 4'hf;
    localparam logic [LANES-1:0] NO_LANES  = 4'h0;
    localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;

    typedef enum logic [1:0] {
        BSS_IDLE  = 2'b00,
        BSS_READ  = 2'b01,
        BSS_WRITE = 2'b10
    } bss_cycle_t;

    // synchronous inputs from the bus master, all active low except select_depth_hi
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              cpu_addr_strobe_n;
        logic              ctl_addr_strobe_n;
        logic              burst_step_n;
        logic              select_pipe_n;
        logic              select_depth_hi;
        logic              select_depth_lo_n;
        logic              all_bytes_write_n;
        logic              lane_write_enable_n;
        logic [LANES-1:0]  lane_write_sel_n;
    } bss_ctl_t;

    // what the array side sees each cycle
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lane_write;
        logic              read_issue;
        logic              selected;
    } bss_access_t;
endpackage : bss_pkg

// >>> rtl/bss_sync.sv
// two-flop synchroniser for the asynchronous pin levels
module bss_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] reset_value,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } bss_sync_state_t;

    bss_sync_state_t state;
    bss_sync_state_t next_state;

    if (WIDTH < 1) begin : g_width_check
        $error("bss_sync: width must be at least one");
    end

    always_comb begin
        next_state = state;
        if (clk_en) begin
            next_state.meta   = async_in;
            next_state.stable = state.meta;
        end
    end

    // reset value is a strap default wire, held constant by the parent
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= '{meta: reset_value, stable: reset_value};
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stable;
endmodule // bss_sync

// >>> tb/bss_front_tb.sv
// self-checking bench for the burst sram front end
module bss_front_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bss_pkg::*;
    typedef struct packed {
        bss_ctl_t    c;
        logic        chk_addr;
        logic        chk_ops;
        bss_access_t e;
    } bss_row_t;
    logic        mclk;
    logic        sys_rst;
    logic        clk_en;
    logic        out_enable_n;
    logic        burst_order_strap;
    logic        burst_interleaved;
    logic [31:0] array_rdata;
    logic [31:0] data_in;
    logic [31:0] wdata;
    logic [31:0] data_out;
    logic [3:0]  data_oe;
    bss_ctl_t    ctl;
    bss_access_t access;
    bss_row_t    rows[$];
    int          n_mismatch;
    int          samples_checked;
    int          cycles;
    bss_host host (.ctl(ctl));
    bss_front uut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .ctl(ctl), .out_enable_n(out_enable_n),
        .burst_order_strap(burst_order_strap), .array_rdata(array_rdata), .data_in(data_in),
        .burst_interleaved(burst_interleaved), .access(access), .wdata(wdata), .data_out(data_out),
        .data_oe(data_oe));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // array stand-in: data tied to the issued address so a stale capture shows
    always @(negedge mclk) array_rdata <= {12'hc3c, access.addr};
    // ceiling well above the roughly 85 cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic bss_ctl_t mk(logic cpu, logic cs, logic st, logic p, logic h, logic l, logic g,
                                    logic be, logic [3:0] s, logic [ADDR_W-1:0] a);
        return bss_ctl_t'{a, cpu, cs, st, p, h, l, g, be, s};
    endfunction
    task automatic add(bss_ctl_t c, logic ca, logic co, logic [ADDR_W-1:0] a, logic [3:0] lw, logic rd, logic sl);
        rows.push_back(bss_row_t'{c, ca, co, bss_access_t'{a, lw, rd, sl}});
    endtask
    // one rising edge per call, entered and left at a falling edge
    task automatic cyc(input bss_ctl_t v);
        host.put(v);
        @(negedge mclk);
    endtask
    task automatic run_rows;
        foreach (rows[i]) begin
            cyc(rows[i].c);
            if (rows[i].chk_addr) chk("addr", 32'(rows[i].e.addr), 32'(access.addr));
            chk("selected", 32'(rows[i].e.selected), 32'(access.selected));
            if (rows[i].chk_ops) begin
                chk("lane_write", 32'(rows[i].e.lane_write), 32'(access.lane_write));
                chk("read_issue", 32'(rows[i].e.read_issue), 32'(access.read_issue));
            end
        end
        rows.delete();
    endtask
    task automatic do_reset(input logic strap);
        burst_order_strap = strap;
        sys_rst = 1'b1;
        repeat (20) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (6) @(negedge mclk);
        chk("burst_interleaved", 32'(strap), 32'(burst_interleaved));
    endtask
    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        out_enable_n = 1'b0;
        burst_order_strap = 1'b1;
        data_in = 32'h0;
        do_reset(1'b1);
        // ****************
        // table of cycles
        // ****************
        add(mk(1, 0, 1, 0, 1, 0, 1, 0, 4'hc, 20'h12345), 1, 1, 20'h12345, 4'h3, 0, 1);
        add(mk(1, 0, 1, 0, 1, 0, 0, 1, 4'hf, 20'h0abc6), 1, 1, 20'h0abc6, 4'hf, 0, 1);
        add(mk(1, 0, 1, 0, 1, 0, 1, 1, 4'h0, 20'h54321), 1, 1, 20'h54321, 4'h0, 1, 1);
        add(mk(0, 1, 1, 0, 1, 0, 1, 1, 4'hf, 20'h0f0f3), 1, 1, 20'h0f0f3, 4'h0, 1, 1);
        add(mk(0, 1, 1, 1, 1, 0, 1, 1, 4'hf, 20'h11111), 1, 1, 20'h0f0f3, 4'h0, 0, 1);
        add(mk(0, 0, 1, 0, 1, 0, 0, 1, 4'hf, 20'h22222), 1, 1, 20'h22222, 4'h0, 1, 1);
        add(mk(0, 0, 1, 1, 1, 0, 1, 1, 4'hf, 20'h33333), 0, 1, 20'h0, 4'h0, 0, 0);
        add(mk(1, 0, 1, 0, 0, 0, 1, 1, 4'hf, 20'h33333), 0, 1, 20'h0, 4'h0, 0, 0);
        add(mk(1, 0, 1, 1, 1, 0, 1, 1, 4'hf, 20'h33333), 0, 1, 20'h0, 4'h0, 0, 0);
        add(mk(1, 0, 1, 0, 1, 1, 1, 1, 4'hf, 20'h33333), 0, 1, 20'h0, 4'h0, 0, 0);
        add(mk(1, 1, 1, 0, 1, 0, 0, 1, 4'hf, 20'h44444), 0, 1, 20'h0, 4'h0, 0, 0);
        add(mk(1, 0, 1, 0, 1, 0, 1, 1, 4'hf, 20'h3cccb), 1, 1, 20'h3cccb, 4'h0, 1, 1);
        add(mk(1, 1, 0, 1, 0, 1, 1, 1, 4'hf, 20'h00000), 1, 0, 20'h3ccca, 4'h0, 0, 1);
        add(mk(1, 1, 0, 1, 0, 1, 1, 1, 4'hf, 20'hfffff), 1, 0, 20'h3ccc9, 4'h0, 0, 1);
        add(mk(1, 1, 0, 1, 0, 1, 1, 1, 4'hf, 20'h00000), 1, 0, 20'h3ccc8, 4'h0, 0, 1);
        add(mk(1, 1, 0, 1, 0, 1, 1, 1, 4'hf, 20'hfffff), 1, 0, 20'h3cccb, 4'h0, 0, 1);
        add(mk(1, 1, 1, 1, 0, 1, 1, 1, 4'hf, 20'h00000), 1, 0, 20'h3cccb, 4'h0, 0, 1);
        add(mk(1, 0, 1, 0, 1, 1, 1, 1, 4'hf, 20'h55555), 0, 1, 20'h0, 4'h0, 0, 0);
        add(mk(1, 1, 0, 0, 1, 0, 0, 1, 4'hf, 20'h55555), 0, 1, 20'h0, 4'h0, 0, 0);
        run_rows();
        // ****************
        // hand-written cases
        // ****************
        clk_en = 1'b0;
        cyc(mk(1, 0, 1, 0, 1, 0, 1, 1, 4'hf, 20'h66666));
        chk("frozen selected", 32'h0, 32'(access.selected));
        clk_en = 1'b1;
        // first read out of deselect keeps pins quiet, the next one drives
        data_in = 32'h1234abcd;
        cyc(mk(0, 1, 1, 0, 1, 0, 1, 1, 4'hf, 20'h00aa0));
        chk("read_issue", 32'h1, 32'(access.read_issue));
        chk("wdata", 32'h1234abcd, wdata);
        cyc(mk(0, 1, 1, 0, 1, 0, 1, 1, 4'hf, 20'h00bb1));
        chk("data_out", 32'hc3c00aa0, data_out);
        cyc(mk(1, 1, 1, 1, 0, 1, 1, 1, 4'hf, 20'h77777));
        chk("data_out", 32'hc3c00bb1, data_out);
        chk("data_oe masked", 32'h0, 32'(data_oe));
        cyc(mk(1, 1, 1, 1, 0, 1, 1, 1, 4'hf, 20'h88888));
        chk("data_oe", 32'hf, 32'(data_oe));
        out_enable_n = 1'b1;
        // reads keep a drive pending while the control is high
        repeat (4) cyc(mk(0, 1, 1, 0, 1, 0, 1, 1, 4'hf, 20'h99999));
        chk("data_oe off", 32'h0, 32'(data_oe));
        do_reset(1'b0);
        add(mk(1, 0, 1, 0, 1, 0, 1, 1, 4'hf, 20'h3cccb), 1, 1, 20'h3cccb, 4'h0, 1, 1);
        add(mk(1, 1, 0, 1, 0, 1, 1, 1, 4'hf, 20'h00000), 1, 0, 20'h3ccc8, 4'h0, 0, 1);
        add(mk(1, 1, 0, 1, 0, 1, 1, 1, 4'hf, 20'hfffff), 1, 0, 20'h3ccc9, 4'h0, 0, 1);
        run_rows();
        give_verdict();
    end
endmodule // bss_front_tb

// >>> tb/bss_host.sv
// host bus master model for the synchronous control inputs
module bss_host (
    output bss_pkg::bss_ctl_t ctl
);
    timeunit 1ns;
    timeprecision 1ps;
    import bss_pkg::*;
    // idle: both strobes and all writes high, no step
    initial ctl = '1;
    // bench calls this at a falling edge; value holds over the next rising edge
    task automatic put(input bss_ctl_t v);
        ctl = v;
    endtask
endmodule // bss_host
